/* cdpc_pkg.sv */
// Shared constants and types for the counter pair block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package cdpc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_SHORT_CTRL = 4'h0;
   localparam logic [3:0] IDX_SHARED_CTRL = 4'h1;
   localparam logic [3:0] IDX_LONG_CTRL = 4'h2;
   localparam logic [3:0] IDX_PAIR_CTRL = 4'h3;
   localparam logic [3:0] IDX_SHORT_HIGH = 4'h4;
   localparam logic [3:0] IDX_SHORT_LOW = 4'h5;
   localparam logic [3:0] IDX_LONG_UPPER = 4'h6;
   localparam logic [3:0] IDX_LONG_LOWER = 4'h7;
   localparam logic [3:0] IDX_CAPTURE = 4'h8;
   localparam logic [3:0] IDX_IRQ_STATUS = 4'h9;
   localparam logic [3:0] IDX_IRQ_MASK = 4'hA;
   localparam logic [3:0] IDX_LAST = 4'hA;
   // Bit positions in the control registers
   localparam int BIT_LONG_EN = 7;
   localparam int BIT_SHORT_EN = 6;
   localparam int BIT_LOCKSTEP = 5;
   localparam int BIT_OWN_EN = 7;
   localparam int BIT_ONE_SHOT = 6;
   localparam int BIT_TIMEOUT = 5;
   // Event bit positions in status and mask
   localparam int EV_SHORT_TC = 0;
   localparam int EV_LONG_TC = 1;
   localparam int EV_CAPTURE = 2;
   // Reset values and the demod wrap value
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_RELOAD = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [2:0] RST_EVENTS = 3'h0;
   localparam logic [15:0] LONG_WRAP = 16'hFFFF;
   // Output submode encodings
   typedef enum logic [1:0] {
      SUB_NORMAL = 2'b00,
      SUB_ALTERNATE = 2'b01,
      SUB_FORCE_LOW = 2'b10,
      SUB_FORCE_HIGH = 2'b11
   } cdpc_submode_type;
   // Shared control register layout
   typedef struct packed {
      logic demod;
      logic spare;
      logic edge_fall;
      logic edge_rise;
      cdpc_submode_type submode;
      logic init_short;
      logic init_long;
   } cdpc_shared_type;
   // One bit per interrupt event
   typedef struct packed {
      logic capture;
      logic long_tc;
      logic short_tc;
   } cdpc_event_type;
endpackage : cdpc_pkg

/* cdpc_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes the pin is asynchronous to the clock.
`timescale 1ns/1ps
module cdpc_pin_sync (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic pin_in,
   output logic rise_out,
   output logic fall_out
);
   logic meta_reg; // First stage, read only by the second
   logic sync_reg; // Second stage
   logic late_reg; // Third stage
   logic level_reg; // Accepted level
   wire agree = (sync_reg == late_reg);
   // Level changes only once two late stages agree
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         late_reg <= 1'b0;
         level_reg <= 1'b0;
      end else if (ce_in) begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         late_reg <= sync_reg;
         if (agree) begin
            level_reg <= late_reg;
         end
      end
   end
   // Pulses last one cycle, the cycle before the level updates
   assign rise_out = ce_in & agree & late_reg & ~level_reg;
   assign fall_out = ce_in & agree & ~late_reg & level_reg;
endmodule : cdpc_pin_sync

/* cdpc_irq.sv */
// Sticky event status, mask and single level interrupt.
// Assumes set and clear vectors come from the same clock domain.
`timescale 1ns/1ps
module cdpc_irq
   import cdpc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire cdpc_pkg::cdpc_event_type set_in,
   input wire cdpc_pkg::cdpc_event_type clr_in,
   input wire logic mask_wr_in,
   input wire cdpc_pkg::cdpc_event_type mask_in,
   output cdpc_pkg::cdpc_event_type status_out,
   output cdpc_pkg::cdpc_event_type mask_out,
   output logic irq_out
);
   import cdpc_pkg::*;
   cdpc_event_type status_reg; // Sticky flags
   cdpc_event_type mask_reg; // Interrupt enables
   // Set wins over a clear in the same cycle
   wire cdpc_event_type status_next = (status_reg & ~clr_in) | set_in;
   // Flags and mask
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_reg <= RST_EVENTS;
         mask_reg <= RST_EVENTS;
      end else if (ce_in) begin
         status_reg <= status_next;
         if (mask_wr_in) begin
            mask_reg <= mask_in;
         end
      end
   end
   assign status_out = status_reg;
   assign mask_out = mask_reg;
   assign irq_out = |(status_reg & mask_reg);
endmodule : cdpc_irq

/* cdpc_top.sv */
// Counter pair: 8-bit short and 16-bit long counter with APB registers.
// Assumes an APB master on MCLK_IN and a carrier pin from outside.
// How it works
// RULE_01 - Pair register: enables bits 7,6, lockstep 5
// RULE_02 - Single-edge demod: first edge only, keep counting
// RULE_03 - Short timeout captures long count, no reload
// RULE_04 - Rewriting one-shot bit re-arms next edge
// RULE_05 - Long zero wraps to all ones, flags
// RULE_06 - Software uses alternating only in transmit
// RULE_07 - Alternating starts with whichever counter enabled
// RULE_08 - Short start takes initial level, reload by level
// RULE_09 - Short end disables short, starts long
// RULE_10 - Long end stops long, restarts short
// RULE_11 - Either terminal count may interrupt when masked in
// RULE_12 - Submode 00 ends alternating, counters independent
// RULE_13 - Software stops counters before alternating mode
// RULE_14 - Submode 10 forces long low, 11 high
// RULE_15 - Long timeout flag clears by writing one
// RULE_16 - Multi-edge demod captures and reloads every edge
// RULE_17 - Lockstep starts both counters on one edge
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module cdpc_top
   import cdpc_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic CARRIER_IN,
   output logic SHORT_COUNTER_OUTPUT_OUT,
   output logic LONG_COUNTER_OUTPUT_OUT,
   output logic IRQ_OUT
);
   import cdpc_pkg::*;

   // Software-visible registers
   logic [7:0] short_counter_control_reg; // Bit 6 selects modulo-N
   cdpc_shared_type shared_counter_control_reg; // Mode, edges, submode, levels
   logic [7:0] long_counter_control_reg; // Bit 6 one-shot
   logic lockstep_reg; // Pair lockstep option
   logic [7:0] short_high_reload_reg;
   logic [7:0] short_low_reload_reg;
   logic [7:0] long_reload_upper_reg;
   logic [7:0] long_reload_lower_reg;
   logic [15:0] capture_reg; // Captured long count
   logic [31:0] prdata_reg; // Read data, loaded in setup
   // Counter state
   logic short_en_reg;
   logic long_en_reg;
   logic [7:0] short_counter_reg;
   logic [15:0] long_counter_reg;
   logic short_out_reg;
   logic long_out_reg;
   logic armed_reg; // One-shot demod may still take an edge
   // Interrupt block and pin synchroniser wires
   cdpc_event_type ev_set;
   cdpc_event_type ev_clr;
   cdpc_event_type ev_status;
   cdpc_event_type ev_mask;
   logic carrier_rise;
   logic carrier_fall;

   // APB decode
   wire [3:0] idx = PADDR_IN[5:2];
   wire addr_ok = (PADDR_IN[1:0] == 2'b00) && (PADDR_IN[7:6] == 2'b00) && (idx <= IDX_LAST);
   wire access = PSEL_IN & PENABLE_IN & CE_IN;
   wire wr = access & PWRITE_IN & addr_ok;
   wire setup_rd = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
   wire wr_short_ctrl = wr & (idx == IDX_SHORT_CTRL);
   wire wr_shared = wr & (idx == IDX_SHARED_CTRL);
   wire wr_long_ctrl = wr & (idx == IDX_LONG_CTRL);
   wire wr_pair = wr & (idx == IDX_PAIR_CTRL);
   wire wr_status = wr & (idx == IDX_IRQ_STATUS);
   wire wr_mask = wr & (idx == IDX_IRQ_MASK);
   wire sw_en_wr = wr_short_ctrl | wr_long_ctrl | wr_pair;
   // Frozen clock enable also stalls the bus
   assign PREADY_OUT = CE_IN;
   assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;

   // Mode decode
   wire demod = shared_counter_control_reg.demod;
   wire transmit = ~demod;
   wire short_modulo = short_counter_control_reg[BIT_ONE_SHOT];
   wire one_shot = long_counter_control_reg[BIT_ONE_SHOT];
   wire [15:0] long_reload = {long_reload_upper_reg, long_reload_lower_reg};
   // RULE_12 submode 00 clears this
   wire alt = transmit & (shared_counter_control_reg.submode == SUB_ALTERNATE);
   wire force_lo = transmit & (shared_counter_control_reg.submode == SUB_FORCE_LOW);
   wire force_hi = transmit & (shared_counter_control_reg.submode == SUB_FORCE_HIGH);

   // Terminal counts
   wire short_tc = short_en_reg & (short_counter_reg == 8'h00);
   wire long_zero = long_en_reg & (long_counter_reg == RST_COUNT);
   wire long_tc_tx = transmit & long_zero;

   // Software enable requests
   // RULE_17 lockstep joins both enables
   wire both_req = PWDATA_IN[BIT_LONG_EN] | PWDATA_IN[BIT_SHORT_EN];
   wire pair_short = PWDATA_IN[BIT_LOCKSTEP] ? both_req : PWDATA_IN[BIT_SHORT_EN];
   wire pair_long = PWDATA_IN[BIT_LOCKSTEP] ? both_req : PWDATA_IN[BIT_LONG_EN];
   wire own_lock_on = lockstep_reg & PWDATA_IN[BIT_OWN_EN];

   // Next enables: software first, then hand-offs and single-pass stops
   logic short_en_next;
   logic long_en_next;
   always_comb begin
      short_en_next = short_en_reg;
      long_en_next = long_en_reg;
      // RULE_01 enable written by software
      if (wr_pair) begin
         short_en_next = pair_short;
         long_en_next = pair_long;
      end else if (wr_short_ctrl) begin
         short_en_next = PWDATA_IN[BIT_OWN_EN];
         if (own_lock_on) begin
            long_en_next = 1'b1;
         end
      end else if (wr_long_ctrl) begin
         long_en_next = PWDATA_IN[BIT_OWN_EN];
         if (own_lock_on) begin
            short_en_next = 1'b1;
         end
      end else begin
         // RULE_09 short end hands off to long
         if (short_tc & (alt | ~short_modulo)) begin
            short_en_next = 1'b0;
         end
         if (alt & short_tc) begin
            long_en_next = 1'b1;
         end
         // RULE_10 long end hands back to short
         if (long_tc_tx & (alt | one_shot)) begin
            long_en_next = 1'b0;
         end
         if (alt & long_tc_tx & ~short_tc) begin
            short_en_next = 1'b1;
         end
      end
   end
   // RULE_07 start is whichever enable rises
   wire short_start = short_en_next & ~short_en_reg;
   wire long_start = long_en_next & ~long_en_reg;

   // Demodulation edge handling
   wire edge_hit = (shared_counter_control_reg.edge_rise & carrier_rise) |
                   (shared_counter_control_reg.edge_fall & carrier_fall);
   // RULE_16 every edge when one-shot is clear
   // RULE_02 only the armed first edge when set
   wire edge_cap = demod & long_en_reg & edge_hit & (~one_shot | armed_reg);
   // RULE_03 short timeout captures without reload
   wire tmo_cap = demod & long_en_reg & one_shot & short_tc;
   logic armed_next;
   always_comb begin
      armed_next = armed_reg;
      // RULE_04 writing zero re-arms for the next edge
      if (~one_shot | long_start) begin
         armed_next = 1'b1;
      end else if (edge_cap) begin
         armed_next = 1'b0;
      end
   end

   // Short counter next value
   wire [7:0] short_pick_init = shared_counter_control_reg.init_short ? short_high_reload_reg : short_low_reload_reg;
   wire [7:0] short_pick_next = short_out_reg ? short_low_reload_reg : short_high_reload_reg;
   logic [7:0] short_counter_next;
   logic short_out_next;
   always_comb begin
      short_counter_next = short_counter_reg;
      short_out_next = short_out_reg;
      if (short_start) begin
         // RULE_08 initial level and reload by that level
         short_out_next = shared_counter_control_reg.init_short;
         short_counter_next = short_pick_init;
      end else if (~short_en_reg) begin
         // Idle level is the opposite, so start shows an edge
         short_out_next = ~shared_counter_control_reg.init_short;
      end else if (short_tc) begin
         short_out_next = ~short_out_reg;
         short_counter_next = short_pick_next;
      end else begin
         short_counter_next = short_counter_reg - 8'h01;
      end
   end

   // Long counter next value
   logic [15:0] long_counter_next;
   logic long_out_next;
   always_comb begin
      long_counter_next = long_counter_reg;
      long_out_next = long_out_reg;
      if (long_start) begin
         // RULE_09 long loads both reload bytes
         long_counter_next = long_reload;
         long_out_next = shared_counter_control_reg.init_long;
      end else if (~long_en_reg) begin
         long_out_next = ~shared_counter_control_reg.init_long;
      end else if (demod) begin
         if (edge_cap) begin
            long_counter_next = long_reload;
         end else if (long_zero) begin
            // RULE_05 wrap and keep counting
            long_counter_next = LONG_WRAP;
         end else begin
            long_counter_next = long_counter_reg - 16'h0001;
         end
      end else if (long_zero) begin
         long_out_next = ~long_out_reg;
         long_counter_next = long_reload;
      end else begin
         long_counter_next = long_counter_reg - 16'h0001;
      end
      // RULE_14 forced levels override at once
      if (force_lo) begin
         long_out_next = 1'b0;
      end else if (force_hi) begin
         long_out_next = 1'b1;
      end
   end

   // Events feeding the sticky status
   // RULE_11 both terminal counts are events
   // One driver per vector: capture, long timeout, short timeout
   assign ev_set = {edge_cap | tmo_cap, long_zero, short_tc};
   // RULE_15 write one clears the long timeout
   assign ev_clr = {wr_status & PWDATA_IN[EV_CAPTURE],
                    (wr_status & PWDATA_IN[EV_LONG_TC]) | (wr_long_ctrl & PWDATA_IN[BIT_TIMEOUT]),
                    wr_status & PWDATA_IN[EV_SHORT_TC]};

   // Read multiplexer
   logic [31:0] rd_mux;
   always_comb begin
      case (idx)
         IDX_SHORT_CTRL: rd_mux = {24'h000000, short_en_reg, short_counter_control_reg[6:0]};
         IDX_SHARED_CTRL: rd_mux = {24'h000000, shared_counter_control_reg};
         IDX_LONG_CTRL: rd_mux = {24'h000000, long_en_reg, long_counter_control_reg[6], ev_status.long_tc,
                                  long_counter_control_reg[4:0]};
         IDX_PAIR_CTRL: rd_mux = {24'h000000, long_en_reg, short_en_reg, lockstep_reg, 5'h00};
         IDX_SHORT_HIGH: rd_mux = {24'h000000, short_high_reload_reg};
         IDX_SHORT_LOW: rd_mux = {24'h000000, short_low_reload_reg};
         IDX_LONG_UPPER: rd_mux = {24'h000000, long_reload_upper_reg};
         IDX_LONG_LOWER: rd_mux = {24'h000000, long_reload_lower_reg};
         IDX_CAPTURE: rd_mux = {16'h0000, capture_reg};
         IDX_IRQ_STATUS: rd_mux = {29'h00000000, ev_status};
         IDX_IRQ_MASK: rd_mux = {29'h00000000, ev_mask};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Configuration registers written by software
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         short_counter_control_reg <= RST_CTRL;
         shared_counter_control_reg <= RST_CTRL;
         long_counter_control_reg <= RST_CTRL;
         lockstep_reg <= 1'b0;
         short_high_reload_reg <= RST_RELOAD;
         short_low_reload_reg <= RST_RELOAD;
         long_reload_upper_reg <= RST_RELOAD;
         long_reload_lower_reg <= RST_RELOAD;
      end else if (wr) begin
         case (idx)
            IDX_SHORT_CTRL: short_counter_control_reg <= PWDATA_IN[7:0];
            IDX_SHARED_CTRL: shared_counter_control_reg <= PWDATA_IN[7:0];
            IDX_LONG_CTRL: long_counter_control_reg <= PWDATA_IN[7:0];
            IDX_PAIR_CTRL: lockstep_reg <= PWDATA_IN[BIT_LOCKSTEP];
            IDX_SHORT_HIGH: short_high_reload_reg <= PWDATA_IN[7:0];
            IDX_SHORT_LOW: short_low_reload_reg <= PWDATA_IN[7:0];
            IDX_LONG_UPPER: long_reload_upper_reg <= PWDATA_IN[7:0];
            IDX_LONG_LOWER: long_reload_lower_reg <= PWDATA_IN[7:0];
            default: lockstep_reg <= lockstep_reg;
         endcase
      end
   end

   // Counter state and read data
   always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         short_en_reg <= 1'b0;
         long_en_reg <= 1'b0;
         short_counter_reg <= RST_RELOAD;
         long_counter_reg <= RST_COUNT;
         short_out_reg <= 1'b0;
         long_out_reg <= 1'b0;
         armed_reg <= 1'b1;
         capture_reg <= RST_COUNT;
         prdata_reg <= 32'h00000000;
      end else if (CE_IN) begin
         short_en_reg <= short_en_next;
         long_en_reg <= long_en_next;
         short_counter_reg <= short_counter_next;
         long_counter_reg <= long_counter_next;
         short_out_reg <= short_out_next;
         long_out_reg <= long_out_next;
         armed_reg <= armed_next;
         if (edge_cap | tmo_cap) begin
            capture_reg <= long_counter_reg;
         end
         if (setup_rd) begin
            prdata_reg <= addr_ok ? rd_mux : 32'h00000000;
         end
      end
   end

   // Carrier pin from outside the clock domain
   cdpc_pin_sync u_sync (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .ce_in(CE_IN),
      .pin_in(CARRIER_IN),
      .rise_out(carrier_rise),
      .fall_out(carrier_fall)
   );
   // Sticky status, mask and interrupt line
   cdpc_irq u_irq (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .ce_in(CE_IN),
      .set_in(ev_set),
      .clr_in(ev_clr),
      .mask_wr_in(wr_mask),
      .mask_in(PWDATA_IN[2:0]),
      .status_out(ev_status),
      .mask_out(ev_mask),
      .irq_out(IRQ_OUT)
   );

   assign PRDATA_OUT = prdata_reg;
   assign SHORT_COUNTER_OUTPUT_OUT = short_out_reg;
   assign LONG_COUNTER_OUTPUT_OUT = long_out_reg;

   // Checks beside the logic
   a_pair_enables: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_01
      (wr_pair & ~PWDATA_IN[BIT_LOCKSTEP]) |=> (short_en_reg == $past(PWDATA_IN[BIT_SHORT_EN])) &&
      (long_en_reg == $past(PWDATA_IN[BIT_LONG_EN])))
      else $error("pair enables not taken from write");
   a_edge_ignored: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_02
      (CE_IN & demod & long_en_reg & one_shot & ~armed_reg & edge_hit & ~short_tc) |=> $stable(capture_reg))
      else $error("later edge captured in one-shot mode");
   a_timeout_capture: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_03
      (CE_IN & tmo_cap & ~edge_cap & ~sw_en_wr & (long_counter_reg != RST_COUNT)) |=>
      (capture_reg == $past(long_counter_reg)) && (long_counter_reg == $past(long_counter_reg) - 16'h0001))
      else $error("timeout capture wrong or reloaded");
   a_rearm_edge: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_04
      (CE_IN & ~one_shot) |=> armed_reg)
      else $error("one-shot not re-armed");
   a_demod_wrap: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_05
      (CE_IN & demod & long_zero & ~edge_cap & ~sw_en_wr) |=> (long_counter_reg == LONG_WRAP) && ev_status.long_tc)
      else $error("long counter did not wrap with flag");
   a_short_init: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_08
      (CE_IN & short_start) |=> (SHORT_COUNTER_OUTPUT_OUT == $past(shared_counter_control_reg.init_short)))
      else $error("short output not at initial level");
   a_hand_long: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_09
      (CE_IN & alt & short_tc & ~long_en_reg & ~sw_en_wr) |=> ~short_en_reg && long_en_reg &&
      (long_counter_reg == $past(long_reload)))
      else $error("short end did not start long");
   a_hand_short: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_10
      (CE_IN & alt & long_tc_tx & ~short_tc & ~sw_en_wr) |=> short_en_reg && ~long_en_reg)
      else $error("long end did not restart short");
   a_force_level: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_14
      (CE_IN & (force_lo | force_hi)) |=> (LONG_COUNTER_OUTPUT_OUT == $past(force_hi)))
      else $error("long output not forced");
   a_timeout_flag: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_15
      (CE_IN & ev_status.long_tc & ~ev_clr.long_tc) |=> ev_status.long_tc)
      else $error("timeout flag cleared without write");
   a_every_edge: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_16
      (CE_IN & edge_cap & ~one_shot & ~sw_en_wr) |=> (long_counter_reg == $past(long_reload)))
      else $error("edge did not reload long counter");
   a_lockstep_start: assert property (@(posedge MCLK_IN) disable iff (RST_IN) // RULE_17
      (wr_pair & PWDATA_IN[BIT_LOCKSTEP]) |=> (short_en_reg == long_en_reg))
      else $error("lockstep enables diverge");
endmodule : cdpc_top

/* cdpc_carrier_model.sv */
// Carrier pin model for the demodulation input.
// Assumes the block samples the pin on its own clock.
`timescale 1ns/1ps
module cdpc_carrier_model (
   input wire logic clk_in,
   output logic carrier_out
);
   // Idle carrier is low
   initial carrier_out = 1'b0;
   // One low-then-high burst, long enough to pass the pin filter
   task automatic burst();
      repeat (6) @(posedge clk_in);
      carrier_out <= 1'b0;
      repeat (6) @(posedge clk_in);
      carrier_out <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask : burst
endmodule : cdpc_carrier_model

/* tb.sv */
// Testbench for the counter pair: APB tasks and scenario sequence.
// Assumes the carrier model on CARRIER_IN; clock enable dropped once near the end.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
   import cdpc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ce = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, c1, c3;
   logic pready, pslverr, carrier, sout, lout, irq, err;
   int errors = 0, cmp_count = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   cdpc_top i_cdpc_top (.MCLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .CARRIER_IN(carrier), .SHORT_COUNTER_OUTPUT_OUT(sout),
      .LONG_COUNTER_OUTPUT_OUT(lout), .IRQ_OUT(irq));
   cdpc_carrier_model i_cdpc_carrier_model (.clk_in(clk), .carrier_out(carrier));
   // Counts, verdict and end of run
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      // A stuck slave ends the run
      if (pready !== 1'b1) begin
         errors++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   // Reads until the masked value appears, bounded
   task automatic poll(input logic [3:0] idx, input logic [31:0] m, input logic [31:0] v);
      int k;
      k = 0;
      do begin
         apb(1'b0, idx, 32'h0);
         k++;
      end while ((rd & m) !== v && k < 40);
      if ((rd & m) !== v) begin
         errors++;
         summarize();
      end
   endtask : poll
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      apb(0, IDX_PAIR_CTRL, 0); `CHK("pair reset", 32'h0, rd);
      apb(0, 4'hF, 0); `CHK("unmapped error", 1'b1, err);
      apb(1, IDX_SHORT_CTRL, 32'h40);
      apb(1, IDX_LONG_CTRL, 32'h00);
      apb(1, IDX_PAIR_CTRL, 32'hA0); apb(0, IDX_PAIR_CTRL, 0); `CHK("lockstep", 32'hE0, rd);
      apb(1, IDX_PAIR_CTRL, 32'h00); apb(0, IDX_PAIR_CTRL, 0); `CHK("stop both", 32'h00, rd);
      $display("test registers done");
      // idle counters and clear flags first
      apb(1, IDX_IRQ_STATUS, 32'h7);
      apb(1, IDX_SHORT_HIGH, 32'h14);
      apb(1, IDX_SHORT_LOW, 32'h14);
      apb(1, IDX_LONG_UPPER, 32'h00);
      apb(1, IDX_LONG_LOWER, 32'h28);
      // single pass on both, alternating while transmitting
      apb(1, IDX_SHORT_CTRL, 32'h00);
      apb(1, IDX_LONG_CTRL, 32'h40);
      apb(1, IDX_SHARED_CTRL, 32'h06);
      apb(1, IDX_IRQ_MASK, 32'h3);
      `CHK("short idle", 1'b0, sout);
      apb(1, IDX_SHORT_CTRL, 32'h80);
      repeat (3) @(negedge clk);
      `CHK("short initial", 1'b1, sout);
      poll(IDX_PAIR_CTRL, 32'hC0, 32'h80);
      `CHK("long initial", 1'b0, lout);
      apb(0, IDX_IRQ_STATUS, 0); `CHK("short tc flag", 1'b1, rd[0]);
      `CHK("irq raised", 1'b1, irq);
      poll(IDX_PAIR_CTRL, 32'hC0, 32'h40);
      apb(0, IDX_IRQ_STATUS, 0); `CHK("long tc flag", 1'b1, rd[1]);
      apb(1, IDX_SHARED_CTRL, 32'h02);
      repeat (60) @(posedge clk);
      apb(0, IDX_PAIR_CTRL, 0); `CHK("no handoff", 32'h00, rd);
      apb(1, IDX_IRQ_MASK, 32'h0);
      apb(1, IDX_IRQ_STATUS, 32'h7);
      apb(0, IDX_IRQ_STATUS, 0); `CHK("status clear", 32'h0, rd);
      `CHK("irq low", 1'b0, irq);
      $display("test alternate done");
      apb(1, IDX_SHARED_CTRL, 32'h08); apb(0, IDX_SHARED_CTRL, 0); `CHK("force low", 1'b0, lout);
      apb(1, IDX_SHARED_CTRL, 32'h0C); apb(0, IDX_SHARED_CTRL, 0); `CHK("force high", 1'b1, lout);
      $display("test force done");
      apb(1, IDX_LONG_LOWER, 32'h10);
      apb(1, IDX_SHARED_CTRL, 32'h90);
      apb(1, IDX_LONG_CTRL, 32'hC0);
      repeat (40) @(posedge clk);
      apb(0, IDX_LONG_CTRL, 0); `CHK("wrap flag", 1'b1, rd[5]);
      apb(1, IDX_LONG_CTRL, 32'hE0); apb(0, IDX_LONG_CTRL, 0); `CHK("flag cleared", 1'b0, rd[5]);
      i_cdpc_carrier_model.burst();
      apb(0, IDX_CAPTURE, 0);
      c1 = rd;
      apb(0, IDX_IRQ_STATUS, 0); `CHK("capture flag", 1'b1, rd[2]);
      i_cdpc_carrier_model.burst();
      apb(0, IDX_CAPTURE, 0); `CHK("later edge ignored", c1, rd);
      apb(1, IDX_LONG_CTRL, 32'h80);
      apb(1, IDX_LONG_CTRL, 32'hC0);
      i_cdpc_carrier_model.burst();
      apb(0, IDX_CAPTURE, 0);
      c3 = rd;
      `CHK("rearmed edge", 1'b1, c3 !== c1);
      apb(1, IDX_LONG_CTRL, 32'h80);
      i_cdpc_carrier_model.burst();
      apb(0, IDX_CAPTURE, 0); `CHK("every edge", 1'b1, rd !== c3);
      // Short timeouts capture in single-edge mode; long timeout flag may also be up
      apb(1, IDX_LONG_CTRL, 32'hC0);
      apb(1, IDX_IRQ_STATUS, 32'h7);
      apb(1, IDX_SHORT_CTRL, 32'hC0);
      repeat (30) @(posedge clk);
      apb(0, IDX_IRQ_STATUS, 0); `CHK("timeout capture", 32'h5, rd & 32'h5);
      `CHK("capture masked", 1'b0, irq);
      apb(1, IDX_IRQ_MASK, 32'h4); apb(0, IDX_IRQ_STATUS, 0); `CHK("capture irq", 1'b1, irq);
      // Frozen clock enable: short output must not toggle, bus stalls
      ce <= 1'b0;
      @(posedge clk);
      c1 = {31'h0, sout};
      repeat (30) @(posedge clk);
      `CHK("frozen output", c1[0], sout);
      `CHK("frozen ready", 1'b0, pready);
      ce <= 1'b1;
      $display("test demod done");
      summarize();
   end
endmodule : tb
